// ==== verilog/sarsr_pkg.sv ====
// Package for the serial readout converter: widths, phases and carriers.
package sarsr_pkg;
   localparam int         RES_BITS      = 12;
   localparam logic [11:0] CODE_FULL    = 12'hfff;
   localparam logic [11:0] CODE_MID     = 12'h800;
   localparam logic [11:0] CODE_MID_M1  = 12'h7ff;
   localparam logic [11:0] CODE_ZERO    = 12'h000;
   // Falling shift-clock edges spent sampling before the null bit
   localparam logic [4:0] SAMPLE_EDGES  = 5'h02;
   // Falling-edge counts at which phases change, counted from select low
   localparam logic [4:0] EDGE_NULL     = 5'h02;
   localparam logic [4:0] EDGE_MSB      = 5'h03;
   localparam logic [4:0] EDGE_LSB      = 5'h0e;
   localparam logic [4:0] EDGE_REV_END  = 5'h19;
   localparam logic [4:0] EDGE_TRI      = 5'h1a;

   typedef enum logic [2:0] {
      SARSR_IDLE,
      SARSR_SAMPLE,
      SARSR_NULL,
      SARSR_CONV,
      SARSR_REPEAT,
      SARSR_DONE
   } sarsr_phase_t;

   // Serial output pin as two signals
   typedef struct packed {
      logic dout;
      logic dout_oe;
   } sarsr_pin_t;

   // Power state of the converter
   typedef struct packed {
      logic analog_pd;
      logic digital_pd;
   } sarsr_power_t;
endpackage

// ==== verilog/sarsr_sync.sv ====
// Two-flop synchroniser with falling and rising edge detection on the second stage.
`timescale 1ns/10ps
`default_nettype none
module sarsr_sync
   import sarsr_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic rst_val,
   // Asynchronous level in, synchronised level out
   input  wire logic din,
   output logic      dout,
   output logic      fall,
   output logic      rise
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Flops store the level relative to rst_val, so reset reads as the idle level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= din ^ rst_val;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign dout = s2_r ^ rst_val;
   assign fall = (s3_r ^ rst_val) & ~(s2_r ^ rst_val);
   assign rise = ~(s3_r ^ rst_val) & (s2_r ^ rst_val);
endmodule
`default_nettype wire

// ==== verilog/sarsr_top.sv ====
// Sequencing, output coding and power control of the serial readout converter.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Result is straight binary: fff full scale, 800 midscale, 7ff below, 000 zero.
// - Power-down holds after conversion completes and whenever select is high.
// - After completion only analog powers down; digital only while select high.
// - Each bit goes out once decided; select high abandons the conversion.
// - Each shift-clock cycle outputs previous decision and decides the next bit.
// - Select low starts; input is sampled for the first two shift-clock periods.
// - After second falling edge output enables with a low null bit, then MSB first.
// - After LSB repeat LSB first; after MSB repeated go tri-state, ignore clocks.
// - New conversion only after select goes high then low again.
module sarsr_top
   import sarsr_pkg::*;
#(
   parameter int RES_W = RES_BITS
)
(
   // System clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Serial link pins from the host
   input  wire logic             conv_sel_n,
   input  wire logic             serial_shift_clock,
   // Comparator decision for the bit under trial
   input  wire logic             cmp_above,
   // Serial output pin
   output logic                  dout,
   output logic                  dout_oe,
   // Trial code driven to the capacitor array
   output logic [RES_W-1:0]      dac_code,
   output logic                  sample_en,
   // Power state and finished result
   output logic                  analog_pd,
   output logic                  digital_pd,
   output logic [RES_W-1:0]      result,
   output logic                  result_valid
);
   logic         sel_n_s;
   logic         sel_fall;
   logic         sel_rise;
   logic         sclk_s;
   logic         sclk_fall;
   logic         sclk_rise;

   sarsr_phase_t phase_r;
   logic [4:0]   edge_cnt_r;
   logic [RES_W-1:0] sar_r;
   logic [RES_W-1:0] trial_r;
   logic [RES_W-1:0] result_r;
   logic         valid_r;
   sarsr_pin_t   pin_r;
   sarsr_power_t pwr_r;

   // Select and shift clock come from pins
   sarsr_sync u_sel (
      .clk     (clk),
      .arst_n  (arst_n),
      .rst_val (1'b1),
      .din     (conv_sel_n),
      .dout    (sel_n_s),
      .fall    (sel_fall),
      .rise    (sel_rise)
   );

   // Shift clock idles low, so no false edge after reset
   sarsr_sync u_sclk (
      .clk     (clk),
      .arst_n  (arst_n),
      .rst_val (1'b0),
      .din     (serial_shift_clock),
      .dout    (sclk_s),
      .fall    (sclk_fall),
      .rise    (sclk_rise)
   );

   // Bit index of the MSB-first step n
   function automatic logic [3:0] msb_idx(input logic [4:0] e);
      msb_idx = 4'(int'(RES_W) - 1 - (int'(e) - int'(EDGE_MSB)));
   endfunction

   // Bit index of the LSB-first repeat step n
   function automatic logic [3:0] lsb_idx(input logic [4:0] e);
      lsb_idx = 4'(int'(e) - int'(EDGE_LSB));
   endfunction

   // Phase sequencing on falling shift-clock edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r    <= SARSR_IDLE;
         edge_cnt_r <= 5'h00;
      end else if (sel_n_s) begin
         phase_r    <= SARSR_IDLE;
         edge_cnt_r <= 5'h00;
      end else begin
         case (phase_r)
            SARSR_IDLE: begin
               if (sel_fall) begin
                  phase_r    <= SARSR_SAMPLE;
                  edge_cnt_r <= 5'h00;
               end
            end
            SARSR_SAMPLE: begin
               if (sclk_fall) begin
                  edge_cnt_r <= edge_cnt_r + 5'h01;
                  if (edge_cnt_r + 5'h01 == SAMPLE_EDGES) begin
                     phase_r <= SARSR_NULL;
                  end
               end
            end
            SARSR_NULL: begin
               if (sclk_fall) begin
                  edge_cnt_r <= edge_cnt_r + 5'h01;
                  phase_r    <= SARSR_CONV;
               end
            end
            SARSR_CONV: begin
               if (sclk_fall) begin
                  edge_cnt_r <= edge_cnt_r + 5'h01;
                  if (edge_cnt_r == EDGE_LSB) begin
                     phase_r <= SARSR_REPEAT;
                  end
               end
            end
            SARSR_REPEAT: begin
               if (sclk_fall) begin
                  edge_cnt_r <= edge_cnt_r + 5'h01;
                  if (edge_cnt_r == EDGE_REV_END) begin
                     phase_r <= SARSR_DONE;
                  end
               end
            end
            SARSR_DONE: begin
               phase_r <= SARSR_DONE;
            end
            default: begin
               phase_r <= SARSR_IDLE;
            end
         endcase
      end
   end

   // Successive approximation: one decision per shift-clock cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sar_r   <= '0;
         trial_r <= '0;
      end else if (sel_n_s || phase_r == SARSR_IDLE) begin
         sar_r   <= '0;
         trial_r <= '0;
      end else if (sclk_fall && phase_r == SARSR_SAMPLE && edge_cnt_r + 5'h01 == SAMPLE_EDGES) begin
         sar_r   <= '0;
         trial_r <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (sclk_rise && phase_r == SARSR_CONV) begin
         // Straight binary: a set bit means input at or above its weight
         if (cmp_above) begin
            sar_r <= sar_r | trial_r;
         end
         trial_r <= trial_r >> 1;
      end else if (sclk_rise && phase_r == SARSR_NULL) begin
         if (cmp_above) begin
            sar_r <= sar_r | trial_r;
         end
         trial_r <= trial_r >> 1;
      end
   end

   // Finished result, kept until the next start
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         result_r <= '0;
         valid_r  <= 1'b0;
      end else if (sel_fall) begin
         valid_r  <= 1'b0;
      end else if (sclk_fall && phase_r == SARSR_CONV && edge_cnt_r == EDGE_LSB) begin
         result_r <= sar_r;
         valid_r  <= 1'b1;
      end
   end

   // Serial output updated on falling shift-clock edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_r <= '{dout: 1'b0, dout_oe: 1'b0};
      end else if (sel_n_s) begin
         pin_r <= '{dout: 1'b0, dout_oe: 1'b0};
      end else if (sclk_fall) begin
         case (phase_r)
            SARSR_SAMPLE: begin
               if (edge_cnt_r + 5'h01 == SAMPLE_EDGES) begin
                  pin_r <= '{dout: 1'b0, dout_oe: 1'b1};
               end
            end
            SARSR_NULL: begin
               pin_r <= '{dout: sar_r[msb_idx(EDGE_MSB)], dout_oe: 1'b1};
            end
            SARSR_CONV: begin
               if (edge_cnt_r == EDGE_LSB) begin
                  pin_r <= '{dout: sar_r[lsb_idx(edge_cnt_r + 5'h01)], dout_oe: 1'b1};
               end else begin
                  pin_r <= '{dout: sar_r[msb_idx(edge_cnt_r + 5'h01)], dout_oe: 1'b1};
               end
            end
            SARSR_REPEAT: begin
               if (edge_cnt_r == EDGE_REV_END) begin
                  pin_r <= '{dout: 1'b0, dout_oe: 1'b0};
               end else begin
                  pin_r <= '{dout: result_r[lsb_idx(edge_cnt_r + 5'h01)], dout_oe: 1'b1};
               end
            end
            default: begin
               pin_r <= pin_r;
            end
         endcase
      end
   end

   // Power state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_r <= '{analog_pd: 1'b1, digital_pd: 1'b1};
      end else begin
         pwr_r.digital_pd <= sel_n_s;
         pwr_r.analog_pd  <= sel_n_s || phase_r == SARSR_IDLE || phase_r == SARSR_REPEAT
                             || phase_r == SARSR_DONE;
      end
   end

   assign dout         = pin_r.dout;
   assign dout_oe      = pin_r.dout_oe;
   assign dac_code     = sar_r | trial_r;
   assign sample_en    = (phase_r == SARSR_SAMPLE) && !sel_n_s;
   assign analog_pd    = pwr_r.analog_pd;
   assign digital_pd   = pwr_r.digital_pd;
   assign result       = result_r;
   assign result_valid = valid_r;
endmodule
`default_nettype wire

// ==== tb/sarsr_top_asserts.sv ====
// Port assertions for the serial readout converter.
`timescale 1ns/10ps
`default_nettype none
module sarsr_top_asserts
   import sarsr_pkg::*;
#(
   parameter int RES_W = RES_BITS
)
(
   // Clock and reset
   input wire logic             clk,
   input wire logic             arst_n,
   // Link and comparator
   input wire logic             conv_sel_n,
   input wire logic             serial_shift_clock,
   input wire logic             cmp_above,
   // Outputs
   input wire logic             dout,
   input wire logic             dout_oe,
   input wire logic [RES_W-1:0] dac_code,
   input wire logic             sample_en,
   input wire logic             analog_pd,
   input wire logic             digital_pd,
   input wire logic [RES_W-1:0] result,
   input wire logic             result_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_sel_tristate: assert property (conv_sel_n [*6] |-> !dout_oe)
      else $error("driven while deselected");
   a_sel_full_pd: assert property (conv_sel_n [*6] |-> analog_pd && digital_pd)
      else $error("awake while deselected");
   a_digital_awake: assert property (!conv_sel_n [*6] |-> !digital_pd)
      else $error("digital off while selected");
   a_done_analog_pd: assert property ($rose(result_valid) |-> ##[0:4] analog_pd)
      else $error("analog on after completion");
   a_null_low: assert property ($rose(dout_oe) |-> !dout)
      else $error("null bit not low");
   a_sample_quiet: assert property (sample_en |-> !dout_oe)
      else $error("driven while sampling");
   a_start_needs_sel: assert property ($rose(dout_oe) |-> !conv_sel_n && !$past(conv_sel_n, 3))
      else $error("output enabled without select");
   a_lsb_shown: assert property ($rose(result_valid) |-> dout_oe && $past(dout) == result[0])
      else $error("last bit not shown");
   a_sample_start: assert property ($fell(conv_sel_n) |-> ##[1:4] sample_en)
      else $error("sampling did not start");
   a_result_hold: assert property (result_valid [*3] |=> $stable(result) || !result_valid)
      else $error("result moved while valid");
   c_done: cover property ($rose(result_valid));
   c_abort: cover property ($fell(dout_oe) && conv_sel_n);
   c_tri_end: cover property ($fell(dout_oe) && !conv_sel_n);
endmodule
`default_nettype wire

// ==== tb/sarsr_host_model.sv ====
// Host serial master and ideal comparator facing the converter.
`timescale 1ns/10ps
`default_nettype none
module sarsr_host_model
   import sarsr_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Link pins
   output logic             conv_sel_n,
   output logic             serial_shift_clock,
   input  wire logic        dout,
   input  wire logic        dout_oe,
   // Analog side
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] vin,
   output logic             cmp_above
);
   logic [31:0] cap_d;
   logic [31:0] cap_oe;
   initial begin
      conv_sel_n = 1'b1;
      serial_shift_clock = 1'b0;
      cmp_above = 1'b0;
   end
   // Ideal comparator
   always @(negedge clk) cmp_above <= (vin >= dac_code);
   // Select low, clock n cycles, capture on rising edges
   task automatic run(input int n);
      conv_sel_n = 1'b0;
      repeat (5) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         serial_shift_clock = 1'b1;
         // Released line reads high through its pull-up
         cap_d[i] = dout_oe ? dout : 1'b1;
         cap_oe[i] = dout_oe;
         repeat (5) @(negedge clk);
         serial_shift_clock = 1'b0;
         repeat (5) @(negedge clk);
      end
   endtask
   // Raise select between conversions
   task automatic release_sel();
      conv_sel_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ==== tb/test_sarsr_top.sv ====
// Self-checking bench for the serial readout converter.
`timescale 1ns/10ps
`default_nettype none
module test_sarsr_top;
   import sarsr_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n;
   logic        conv_sel_n;
   logic        serial_shift_clock;
   logic        cmp_above;
   logic        dout;
   logic        dout_oe;
   logic [11:0] dac_code;
   logic        sample_en;
   logic        analog_pd;
   logic        digital_pd;
   logic [11:0] result;
   logic        result_valid;
   logic [11:0] vin;
   int          mismatches;
   int          tests_run;
   sarsr_top #(.RES_W(RES_BITS)) u_sarsr_top (.clk(clk), .arst_n(arst_n), .conv_sel_n(conv_sel_n),
      .serial_shift_clock(serial_shift_clock), .cmp_above(cmp_above), .dout(dout), .dout_oe(dout_oe),
      .dac_code(dac_code), .sample_en(sample_en), .analog_pd(analog_pd), .digital_pd(digital_pd),
      .result(result), .result_valid(result_valid));
   sarsr_host_model u_sarsr_host_model (.clk(clk), .conv_sel_n(conv_sel_n),
      .serial_shift_clock(serial_shift_clock), .dout(dout), .dout_oe(dout_oe), .dac_code(dac_code),
      .vin(vin), .cmp_above(cmp_above));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Full conversion, repeat, power states, release
   task automatic t_full(input logic [11:0] code);
      logic [11:0] fwd;
      logic [11:0] rev;
      vin = code;
      u_sarsr_host_model.run(27);
      for (int i = 0; i < 12; i++) begin
         fwd[11-i] = u_sarsr_host_model.cap_d[3+i];
         rev[i] = u_sarsr_host_model.cap_d[14+i];
      end
      chk("oe_window", 32'h03fffffc, u_sarsr_host_model.cap_oe & 32'h07ffffff);
      chk("null_bit", 32'h0, {31'h0, u_sarsr_host_model.cap_d[2]});
      chk("msb_first", {20'h0, code}, {20'h0, fwd});
      chk("lsb_repeat", {20'h0, code}, {20'h0, rev});
      chk("result", {19'h0, 1'b1, code}, {19'h0, result_valid, result});
      chk("pd_done", 32'h2, {30'h0, analog_pd, digital_pd});
      u_sarsr_host_model.release_sel();
      chk("pd_idle", 32'h3, {30'h0, analog_pd, digital_pd});
   endtask
   // Coding boundary values
   task automatic t_codes();
      t_full(12'hfff);
      t_full(12'h800);
      t_full(12'h7ff);
      t_full(12'h000);
   endtask
   // Cut short after eight bits, then a clean restart
   task automatic t_short();
      logic [7:0] got;
      vin = 12'ha5c;
      u_sarsr_host_model.run(11);
      for (int i = 0; i < 8; i++) begin
         got[7-i] = u_sarsr_host_model.cap_d[3+i];
      end
      chk("short_bits", 32'ha5, {24'h0, got});
      chk("short_valid", 32'h0, {31'h0, result_valid});
      u_sarsr_host_model.release_sel();
      chk("abort_pins", 32'h1, {30'h0, dout_oe, digital_pd});
      t_full(12'h5a3);
   endtask
   always #4 clk = ~clk;
   initial begin
      arst_n = 1'b0;
      vin = 12'h000;
      mismatches = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_codes();
      t_short();
      report_and_stop();
   end
   initial begin
      #160000;
      mismatches++;
      report_and_stop();
   end
endmodule
bind sarsr_top sarsr_top_asserts #(.RES_W(RES_W)) u_sarsr_top_asserts (.clk(clk), .arst_n(arst_n),
   .conv_sel_n(conv_sel_n), .serial_shift_clock(serial_shift_clock), .cmp_above(cmp_above), .dout(dout),
   .dout_oe(dout_oe), .dac_code(dac_code), .sample_en(sample_en), .analog_pd(analog_pd),
   .digital_pd(digital_pd), .result(result), .result_valid(result_valid));
`default_nettype wire
